// file: tb/vectored_interrupt_prioritizer_test.sv
// testbench: scoreboarded vectors, levels, gate and fixed slots
module vectored_interrupt_prioritizer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [6:0] periph_pulse = '0;
   logic [7:0] pa_pin = '0, pa_fall_sel = '0;
   logic [3:0] pc_pin = '0, wait_cyc = '0;
   logic wd_pulse = 0, wd_en = 0, trap_pulse = 0, gate_set = 0, gate_clr = 0;
   logic pend_wr = 0, ack, req_q, fixed_q, global_irq_gate_q;
   logic [18:0] pend_wdata = '0, pend_q, pm;
   logic [37:0] src_level = '0;
   logic [15:0] vec_q;
   logic [16:0] exp_q[$];
   logic [1:0] lv[19];
   int err_total = 0, compares = 0, seed = 3208, cycles = 0;
   initial forever #5 clk_sys = ~clk_sys;
   vip_top dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
      .periph_pulse(periph_pulse), .pa_pin(pa_pin), .pc_pin(pc_pin),
      .watchdog_timer_pulse(wd_pulse), .watchdog_irq_en(wd_en),
      .trap_pulse(trap_pulse), .pa_fall_sel(pa_fall_sel),
      .src_level(src_level), .gate_set(gate_set), .gate_clr(gate_clr),
      .pend_wr(pend_wr), .pend_wdata(pend_wdata), .ack(ack), .req_q(req_q),
      .vec_q(vec_q), .fixed_q(fixed_q), .pend_q(pend_q),
      .global_irq_gate_q(global_irq_gate_q));
   vip_core_model core_u (.clk_sys(clk_sys), .req_q(req_q),
      .wait_cyc(wait_cyc), .ack(ack));
   task check(string nm, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task summarize();
      if (err_total == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task gate();
      @(negedge clk_sys);
      gate_set = 1'b1;
      @(negedge clk_sys);
      gate_set = 1'b0;
   endtask
   // one-cycle pulse or a single pin change per event
   task fire(int s);
      @(negedge clk_sys);
      if (s < 7) periph_pulse[s] = 1'b1;
      else if (s < 15) pa_pin[14 - s] = ~pa_pin[14 - s];
      else pc_pin[18 - s] = ~pc_pin[18 - s];
      @(negedge clk_sys);
      periph_pulse = '0;
   endtask
   function logic [15:0] vec_of(int s);
      if (s < 7) return 16'h000a + 16'(2 * s);
      if (s < 15) return 16'h0018 + 16'(2 * (s - 7));
      return 16'h0030 + 16'(2 * (s - 15));
   endfunction
   // bounded wait: all notes consumed and the request gone
   task drain();
      int n;
      n = 0;
      while ((exp_q.size() != 0 || req_q !== 1'b0) && n < 200) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 200) check("drain", 1, 0);
   endtask
   // ceiling far above the several hundred cycles the scenarios need
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_total++;
         summarize();
      end
   end
   always @(posedge clk_sys) begin
      if (req_q === 1'b1 && ack === 1'b1) begin
         if (exp_q.size() == 0) check("extra", 1, 0);
         else check("vector", {fixed_q, vec_q}, exp_q.pop_front());
         check("even", vec_q[0], 0);
      end
   end
   initial begin
      repeat (3) @(negedge clk_sys);
      reset_n = 1'b1;
      check("reset", {pend_q, req_q, global_irq_gate_q}, 0);
      for (int i = 0; i < 19; i++) src_level[2*i +: 2] = 2'h1;
      for (int s = 0; s < 19; s++) begin
         wait_cyc = 4'($random(seed)) & 4'h3;
         gate();
         exp_q.push_back({1'b0, vec_of(s)});
         fire(s);
         drain();
         check("gate", global_irq_gate_q, 0);
         check("pend", pend_q, 0);
      end
      // pins now high: reverse edges; port A by random edge choice
      pa_fall_sel = 8'($random(seed));
      for (int s = 7; s < 19; s++) begin
         gate();
         if (s > 14 || pa_fall_sel[14 - s]) exp_q.push_back({1'b0, vec_of(s)});
         fire(s);
         repeat (3) @(negedge clk_sys);
         drain();
         check("edge", pend_q, 0);
      end
      // clear wins over set; request waits in pending only
      @(negedge clk_sys);
      {gate_set, gate_clr} = 2'h3;
      @(negedge clk_sys);
      {gate_set, gate_clr} = 2'h0;
      fire(0);
      repeat (4) @(negedge clk_sys);
      check("poll", {req_q, pend_q}, 20'h00001);
      repeat (3) begin
         for (int i = 0; i < 19; i++) begin
            lv[i] = 2'($random(seed));
            src_level[2*i +: 2] = lv[i];
         end
         @(negedge clk_sys);
         {pend_wr, pend_wdata} = {1'b1, 19'h7ffff};
         @(negedge clk_sys);
         pend_wr = 1'b0;
         pm = '1;
         repeat (19) begin
            int b;
            b = -1;
            for (int i = 0; i < 19; i++)
               if (pm[i] && lv[i] != 0 && (b < 0 || lv[i] > lv[b])) b = i;
            if (b >= 0) begin
               pm[b] = 1'b0;
               exp_q.push_back({1'b0, vec_of(b)});
               gate();
               drain();
            end
         end
         check("left", pend_q, pm);
      end
      @(negedge clk_sys);
      {pend_wr, pend_wdata} = {1'b1, 19'h00000};
      @(negedge clk_sys);
      pend_wr = 1'b0;
      check("swclr", pend_q, 0);
      gate();
      exp_q.push_back({1'b1, 16'h0006});
      exp_q.push_back({1'b1, 16'h0004});
      @(negedge clk_sys);
      {trap_pulse, wd_pulse, wd_en} = 3'h7;
      @(negedge clk_sys);
      {trap_pulse, wd_pulse} = 2'h0;
      drain();
      check("trapgate", global_irq_gate_q, 0);
      wd_en = 1'b0;
      @(negedge clk_sys);
      wd_pulse = 1'b1;
      @(negedge clk_sys);
      wd_pulse = 1'b0;
      repeat (5) @(negedge clk_sys);
      check("wd_off", req_q, 0);
      summarize();
   end
endmodule

// file: tb/vip_core_model.sv
// partner: processor core that accepts presented requests
module vip_core_model (
   // clock
   input wire logic clk_sys,
   // handshake
   input wire logic req_q,
   input wire logic [3:0] wait_cyc,
   output logic ack
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   initial ack = 1'b0;
   // one ack per request, only while it stands; delay varies
   always @(negedge clk_sys) begin
      if (ack || req_q !== 1'b1) begin
         ack <= 1'b0;
         cnt <= 0;
      end else if (cnt >= wait_cyc) begin
         ack <= 1'b1;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

// file: verilog/vip_pkg.sv
// package: constants and types for the vectored interrupt prioritizer
package vip_pkg;
   localparam int unsigned NUM_SRC = 19;
   localparam int unsigned NUM_PERIPH = 7;
   localparam int unsigned NUM_PA = 8;
   localparam int unsigned NUM_PC = 4;
   localparam logic [15:0] VEC_RESET = 16'h0002;
   localparam logic [15:0] VEC_WATCHDOG = 16'h0004;
   localparam logic [15:0] VEC_TRAP = 16'h0006;
   localparam logic [15:0] VEC_RSVD = 16'h0008;
   localparam logic [15:0] VEC_PERIPH0 = 16'h000a;
   localparam logic [15:0] VEC_PA0 = 16'h0018;
   localparam logic [15:0] VEC_PC0 = 16'h0030;
   localparam logic [1:0] LVL_OFF = 2'h0;
   localparam logic [18:0] PEND_RESET = 19'h00000;
   localparam logic [37:0] LVL_RESET = 38'h0000000000;
   localparam logic [7:0] EDGE_RESET = 8'h00;
   localparam logic GATE_RESET = 1'b0;
   typedef logic [4:0] vip_idx_t;
   typedef enum logic [1:0] {VIP_NONE, VIP_MASK, VIP_FIXED} vip_kind_t;
endpackage

// file: verilog/vip_ranker.sv
// module: level then fixed-order selection of one pending request
module vip_ranker (
   // requests
   input wire logic [18:0] pend,
   input wire logic [37:0] lvl,
   // winner
   vip_win_if.ranker win
);
   // bit i is slot i in descending fixed order: 0..6 periph, 7..14 pa7..0,
   // 15..18 pc3..0
   function automatic logic [15:0] slot_vec(input logic [4:0] i);
      logic [15:0] v;
      v = 16'h0000;
      if (i < 5'h07) begin
         v = vip_pkg::VEC_PERIPH0 + {10'h000, i, 1'b0};
      end else if (i < 5'h0f) begin
         v = vip_pkg::VEC_PA0 + {10'h000, i - 5'h07, 1'b0};
      end else begin
         v = vip_pkg::VEC_PC0 + {10'h000, i - 5'h0f, 1'b0};
      end
      return v;
   endfunction
   always_comb begin
      logic [1:0] best;
      best = vip_pkg::LVL_OFF;
      win.found = 1'b0;
      win.idx = 5'h00;
      // strict greater keeps the earliest (highest fixed) slot per level
      for (int i = 0; i < 19; i++) begin
         if (pend[i] && lvl[2*i +: 2] > best) begin
            best = lvl[2*i +: 2];
            win.found = 1'b1;
            win.idx = 5'(i);
         end
      end
      win.vec = slot_vec(win.idx);
   end
endmodule

// file: verilog/vip_top.sv
// module: vectored interrupt prioritizer top
// Function
// - nineteen vectors come from twelve port pins and seven peripherals.
// - each of eight port A pins requests on a per-pin chosen edge.
// - port C pins 3..0 request on both edges at vectors 0030h to 0036h.
// - each of the nineteen maskable sources has its own level, off or one of three.
// - an enabled watchdog interrupt is taken at vector 0004h.
// - vector entries hold the handler high byte even, low byte odd.
// - reset and trap use 0002h and 0006h unmasked; 0008h is unused.
// - peripherals rank in fixed order from 000ah down to 0016h.
// - port A pins 7..0 map to 0018h..0026h; 0028h..002eh are reserved.
// - with the gate off only trap and watchdog are vectored and pending stays readable.
// - a global gate, set by enable/return/write one, cleared otherwise.
// - one-cycle source pulses latch into pending bits until cleared.
// - writing one raises, zero clears a pending bit; ack clears it too.
// - a higher level always wins; fixed order only breaks ties.
module vip_top (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // sources
   input wire logic [6:0] periph_pulse,
   input wire logic [7:0] pa_pin,
   input wire logic [3:0] pc_pin,
   input wire logic watchdog_timer_pulse,
   input wire logic watchdog_irq_en,
   input wire logic trap_pulse,
   // configuration
   input wire logic [7:0] pa_fall_sel,
   input wire logic [37:0] src_level,
   // software and core controls
   input wire logic gate_set,
   input wire logic gate_clr,
   input wire logic pend_wr,
   input wire logic [18:0] pend_wdata,
   input wire logic ack,
   // to core
   output logic req_q,
   output logic [15:0] vec_q,
   output logic fixed_q,
   output logic [18:0] pend_q,
   output logic global_irq_gate_q
);
   logic [7:0] pa_prev_q;
   logic [3:0] pc_prev_q;
   logic wd_pend_q;
   logic trap_pend_q;
   vip_pkg::vip_idx_t win_idx_q;
   vip_pkg::vip_kind_t kind_q;
   logic [18:0] raw_ev;
   logic [18:0] pend_d;
   logic [7:0] pa_rise;
   logic [7:0] pa_fall;
   vip_win_if win ();

   vip_ranker u_rank (
      .pend(pend_q),
      .lvl(src_level),
      .win(win)
   );

   // previous pin levels; pins are synchronous already
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         // track pins in reset too, so a pin idling high gives no false edge
         pa_prev_q <= pa_pin;
         pc_prev_q <= pc_pin;
      end else begin
         pa_prev_q <= pa_pin;
         pc_prev_q <= pc_pin;
      end
   end

   always_comb begin
      pa_rise = pa_pin & ~pa_prev_q;
      pa_fall = ~pa_pin & pa_prev_q;
      raw_ev[6:0] = periph_pulse;
      for (int i = 0; i < 8; i++) begin
         // slot 7 is pa7 down to slot 14 pa0
         raw_ev[7+i] = pa_fall_sel[7-i] ? pa_fall[7-i] : pa_rise[7-i];
      end
      for (int i = 0; i < 4; i++) begin
         raw_ev[15+i] = pc_pin[3-i] ^ pc_prev_q[3-i];
      end
   end

   // software write first, then ack clear, then new events: set beats clear
   always_comb begin
      pend_d = pend_q;
      if (pend_wr) begin
         pend_d = pend_wdata;
      end
      if (ack && kind_q == vip_pkg::VIP_MASK) begin
         pend_d[win_idx_q] = 1'b0;
      end
      pend_d = pend_d | raw_ev;
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         pend_q <= vip_pkg::PEND_RESET;
      end else begin
         pend_q <= pend_d;
      end
   end

   // fixed top slots are held apart from maskable pending bits
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         wd_pend_q <= 1'b0;
         trap_pend_q <= 1'b0;
      end else begin
         wd_pend_q <= (watchdog_timer_pulse && watchdog_irq_en) ||
                      (wd_pend_q && !(ack && kind_q == vip_pkg::VIP_FIXED &&
                       vec_q == vip_pkg::VEC_WATCHDOG));
         trap_pend_q <= trap_pulse ||
                        (trap_pend_q && !(ack && kind_q == vip_pkg::VIP_FIXED &&
                         vec_q == vip_pkg::VEC_TRAP));
      end
   end

   // gate: clears win over sets since ack and trap both disable
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         global_irq_gate_q <= vip_pkg::GATE_RESET;
      end else if (gate_clr || ack || trap_pulse) begin
         global_irq_gate_q <= 1'b0;
      end else if (gate_set) begin
         global_irq_gate_q <= 1'b1;
      end
   end

   // presented request latches and holds until ack; vector 0002h is only
   // ever fetched by the core on reset, never presented here
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         req_q <= 1'b0;
         vec_q <= 16'h0000;
         fixed_q <= 1'b0;
         kind_q <= vip_pkg::VIP_NONE;
         win_idx_q <= 5'h00;
      end else if (req_q) begin
         if (ack) begin
            req_q <= 1'b0;
            fixed_q <= 1'b0;
            kind_q <= vip_pkg::VIP_NONE;
         end
      end else if (trap_pend_q) begin
         req_q <= 1'b1;
         vec_q <= vip_pkg::VEC_TRAP;
         fixed_q <= 1'b1;
         kind_q <= vip_pkg::VIP_FIXED;
      end else if (wd_pend_q) begin
         req_q <= 1'b1;
         vec_q <= vip_pkg::VEC_WATCHDOG;
         fixed_q <= 1'b1;
         kind_q <= vip_pkg::VIP_FIXED;
      end else if (global_irq_gate_q && win.found) begin
         req_q <= 1'b1;
         vec_q <= win.vec;
         kind_q <= vip_pkg::VIP_MASK;
         win_idx_q <= win.idx;
      end
   end

   sequence pa_edge_s(int i);
      !pa_fall_sel[i] && !pa_pin[i] ##1 pa_pin[i] && !pa_fall_sel[i];
   endsequence

   // winner ready while nothing stands and no fixed slot is pending
   sequence present_s;
      !req_q && global_irq_gate_q && win.found && !wd_pend_q && !trap_pend_q;
   endsequence

   pa_rise_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      pa_edge_s(7) |=> pend_q[7])
      else $error("pa7 rising edge not latched");
   pc_both_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      $changed(pc_pin[0]) && $past(reset_n) |=> pend_q[18])
      else $error("pc0 edge not latched");
   periph_latch_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      periph_pulse[0] |=> pend_q[0])
      else $error("peripheral pulse lost");
   req_hold_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      req_q && !ack |=> req_q && $stable(vec_q))
      else $error("request changed before ack");
   gate_ack_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      ack |=> !global_irq_gate_q)
      else $error("gate not cleared by ack");
   no_gate_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      !req_q && !global_irq_gate_q && !wd_pend_q && !trap_pend_q
      |=> !req_q)
      else $error("vectored while gate off");
   trap_first_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      !req_q && trap_pend_q |=> req_q && vec_q == vip_pkg::VEC_TRAP)
      else $error("trap not presented");
   vec_range_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      req_q && !fixed_q |-> vec_q >= 16'h000a && vec_q <= 16'h0036 &&
      !vec_q[0] && !(vec_q >= 16'h0028 && vec_q <= 16'h002e))
      else $error("vector out of map");
   sw_clear_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      pend_wr && !pend_wdata[0] && !periph_pulse[0] |=> !pend_q[0])
      else $error("software clear failed");
   gate_set_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      gate_set && !gate_clr && !ack && !trap_pulse |=> global_irq_gate_q)
      else $error("gate not set");
   trap_gate_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      trap_pulse |=> !global_irq_gate_q)
      else $error("gate not cleared by trap");
   ack_clear_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      req_q && ack && !fixed_q && !pend_wr && !raw_ev[win_idx_q]
      |=> !pend_q[win_idx_q])
      else $error("serviced pending bit not cleared");
   wd_next_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      !req_q && wd_pend_q && !trap_pend_q
      |=> req_q && fixed_q && vec_q == vip_pkg::VEC_WATCHDOG)
      else $error("watchdog not presented");
   wd_masked_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      !watchdog_irq_en && !wd_pend_q |=> !wd_pend_q)
      else $error("watchdog taken while not enabled");
   vec_even_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      req_q |-> !vec_q[0])
      else $error("vector entry not on even address");
   present_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      present_s |=> req_q && !fixed_q)
      else $error("winner not presented");
endmodule

// file: verilog/vip_win_if.sv
// interface: winner from the ranking logic to the top
interface vip_win_if;
   logic found;
   logic [4:0] idx;
   logic [15:0] vec;
   modport ranker (output found, idx, vec);
   modport user (input found, idx, vec);
endinterface
